//--- rtl/front_panel_indicator_ctrl.sv
/*
  Front-panel lamp and switch logic: lamp test, drive lamps, carrier and
  status lamps, configuration check, baud selectors, binary switch, APB regs.
  Assumes all pin inputs synchronous to clock; firmware drives the events.
*/
`timescale 1ns/1ps
module front_panel_indicator_ctrl #(
  parameter int unsigned LAMP_TEST_CYCLES = panel_pkg::LAMP_TEST_CYCLES_DEF,
  parameter int unsigned DIM_HALF_CYCLES  = panel_pkg::DIM_HALF_CYCLES_DEF
) (
  input  logic                   clock,
  input  logic                   rst,
  input  panel_pkg::apb_req_s    apb_req,
  output panel_pkg::apb_rsp_s    apb_rsp,
  input  logic [1:0]             diskette_seated,
  input  logic [1:0]             disk_xfer_active,
  input  logic [1:0]             drive_safe,
  input  logic [2:0]             port_xfer_active,
  input  logic                   parity_error,
  input  logic                   carrier_detect,
  input  logic                   restart_switch,
  input  logic                   binary_exit_switch,
  input  logic [2:0][3:0]        baud_selector,
  input  logic [7:0]             cfg_test_byte,
  input  logic                   cfg_refresh_done,
  output panel_pkg::lamps_s      lamps,
  output logic [2:0][15:0]       baud_divisor,
  output logic                   binary_mode,
  output logic                   op_enable,
  output logic                   system_restart,
  output logic                   disk_abort
);

  typedef struct packed {
    panel_pkg::panel_state_e st;
    logic [31:0]             lt_cnt;
    logic                    parity;
    logic                    cfg_bad;
    logic [1:0]              abort_pend;
    logic                    standby;
    logic                    restart_prev;
    logic [2:0][3:0]         sel;
    logic [2:0][15:0]        keyrate;
    logic [2:0][15:0]        baud;
    panel_pkg::lamps_s       lamps;
    panel_pkg::apb_rsp_s     rsp;
    logic                    binary_mode;
    logic                    op_enable;
    logic                    sys_restart;
    logic                    disk_abort;
  } ctrl_state_s;

  ctrl_state_s s_r;
  ctrl_state_s s_nxt;

  logic       dim_phase;
  logic       access;
  logic       take;
  logic       wr_fire;
  logic       reset_cmd;
  logic       restart_edge;
  logic       any_port;
  logic [7:0] waddr;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] baud_div(input logic [3:0]  sel,
                                           input logic [15:0] kbd);
    if (sel >= 4'h1 && sel <= 4'h9) begin
      return panel_pkg::DIV_TAB[sel - 4'h1];
    end
    return kbd;
  endfunction : baud_div

  function automatic logic reg_ok(input logic [7:0] a);
    return a == panel_pkg::OFS_CTRL     || a == panel_pkg::OFS_STATUS   ||
           a == panel_pkg::OFS_KEYRATE0 || a == panel_pkg::OFS_KEYRATE1 ||
           a == panel_pkg::OFS_KEYRATE2 || a == panel_pkg::OFS_SELECT;
  endfunction : reg_ok

  function automatic logic [31:0] reg_rd(input logic [7:0]  a,
                                         input ctrl_state_s st);
    logic [31:0] d;
    d = 32'h0;
    unique case (a)
      panel_pkg::OFS_CTRL:
        d[panel_pkg::CTRL_STANDBY_BIT] = st.standby;
      panel_pkg::OFS_STATUS:
        d[13:0] = {st.op_enable, st.st, st.cfg_bad, st.parity,
                   st.abort_pend, st.lamps};
      panel_pkg::OFS_KEYRATE0: d[15:0] = st.keyrate[0];
      panel_pkg::OFS_KEYRATE1: d[15:0] = st.keyrate[1];
      panel_pkg::OFS_KEYRATE2: d[15:0] = st.keyrate[2];
      panel_pkg::OFS_SELECT:   d[11:0] = st.sel;
      default:                 d = 32'h0;
    endcase
    return d;
  endfunction : reg_rd

  // ----------------------------------------------------------------
  // Dimming source
  // ----------------------------------------------------------------
  dim_gen #(
    .HALF_CYCLES (DIM_HALF_CYCLES)
  ) u_dim (
    .clock (clock),
    .rst   (rst),
    .phase (dim_phase)
  );

  // ----------------------------------------------------------------
  // Bus and event decode
  // ----------------------------------------------------------------
  assign access  = apb_req.psel & apb_req.penable;
  assign take    = access & ~s_r.rsp.pready;
  // Write lands only at the edge where the master sees pready
  assign wr_fire = access & s_r.rsp.pready & apb_req.pwrite;
  assign waddr   = apb_req.paddr;
  assign reset_cmd = wr_fire && waddr == panel_pkg::OFS_CTRL &&
                     apb_req.pwdata[panel_pkg::CTRL_RESET_BIT];
  assign restart_edge = restart_switch & ~s_r.restart_prev;
  assign any_port     = |port_xfer_active;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.restart_prev = restart_switch;

    // APB slave: one wait state, then answer for one cycle
    s_nxt.rsp.pready = take;
    if (take) begin
      s_nxt.rsp.prdata  = reg_rd(waddr, s_r);
      s_nxt.rsp.pslverr = ~reg_ok(waddr);
    end else begin
      s_nxt.rsp.prdata  = 32'h0;
      s_nxt.rsp.pslverr = 1'b0;
    end
    if (wr_fire) begin
      unique case (waddr)
        panel_pkg::OFS_CTRL:
          s_nxt.standby = apb_req.pwdata[panel_pkg::CTRL_STANDBY_BIT];
        panel_pkg::OFS_KEYRATE0: s_nxt.keyrate[0] = apb_req.pwdata[15:0];
        panel_pkg::OFS_KEYRATE1: s_nxt.keyrate[1] = apb_req.pwdata[15:0];
        panel_pkg::OFS_KEYRATE2: s_nxt.keyrate[2] = apb_req.pwdata[15:0];
        default: ;
      endcase
    end

    // Parity: a new error wins over a same-cycle reset command
    s_nxt.parity = parity_error | (s_r.parity & ~reset_cmd);

    // Abort pending until each drive reports it is safe to unload
    s_nxt.disk_abort = reset_cmd;
    s_nxt.abort_pend = {2{reset_cmd}} | (s_r.abort_pend & ~drive_safe);

    s_nxt.binary_mode = ~binary_exit_switch;
    s_nxt.sys_restart = restart_edge;

    unique case (s_r.st)
      panel_pkg::ST_LAMP_TEST: begin
        if (s_r.lt_cnt == 32'(LAMP_TEST_CYCLES - 1)) begin
          s_nxt.lt_cnt = 32'h0;
          s_nxt.st     = panel_pkg::ST_CHECK;
        end else begin
          s_nxt.lt_cnt = s_r.lt_cnt + 32'h1;
        end
      end
      panel_pkg::ST_CHECK: begin
        s_nxt.sel     = baud_selector;
        s_nxt.cfg_bad = cfg_test_byte != panel_pkg::CFG_TEST_EXPECTED;
        s_nxt.st      = panel_pkg::ST_RUN;
      end
      panel_pkg::ST_RUN: begin
        if (cfg_refresh_done) begin
          s_nxt.cfg_bad = 1'b0;
        end
      end
      default: begin
        s_nxt.st = panel_pkg::ST_LAMP_TEST;
      end
    endcase
    // A press restarts from any state, retesting lamps and rereading switches
    if (restart_edge) begin
      s_nxt.st     = panel_pkg::ST_LAMP_TEST;
      s_nxt.lt_cnt = 32'h0;
    end

    for (int i = 0; i < 3; i++) begin
      s_nxt.baud[i] = baud_div(s_r.sel[i], s_r.keyrate[i]);
    end

    s_nxt.op_enable = (s_r.st == panel_pkg::ST_RUN) & ~s_r.cfg_bad;

    if (s_r.st == panel_pkg::ST_LAMP_TEST) begin
      s_nxt.lamps = '1;
    end else begin
      s_nxt.lamps.ready   = diskette_seated & ~{2{s_r.standby}};
      s_nxt.lamps.busy    = disk_xfer_active | s_r.abort_pend;
      s_nxt.lamps.carrier = carrier_detect;
      s_nxt.lamps.restart = 1'b1;
      if (s_r.cfg_bad) begin
        s_nxt.lamps.status = 1'b1;
      end else if (any_port) begin
        s_nxt.lamps.status = dim_phase;
      end else begin
        s_nxt.lamps.status = s_r.parity;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r         <= '0;
      s_r.st      <= panel_pkg::ST_LAMP_TEST;
      s_r.standby <= panel_pkg::STANDBY_RST;
      s_r.keyrate <= {3{panel_pkg::KEYRATE_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign apb_rsp        = s_r.rsp;
  assign lamps          = s_r.lamps;
  assign baud_divisor   = s_r.baud;
  assign binary_mode    = s_r.binary_mode;
  assign op_enable      = s_r.op_enable;
  assign system_restart = s_r.sys_restart;
  assign disk_abort     = s_r.disk_abort;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Release edge skipped: next state was not yet computed there
  AST_LAMP_TEST: assert property (
    s_r.st == panel_pkg::ST_LAMP_TEST && !$past(rst) |=> lamps == 7'h7f)
    else $error("lamp test not lighting every lamp");

  AST_LT_LENGTH: assert property (
    s_r.st == panel_pkg::ST_LAMP_TEST && s_r.lt_cnt == 32'(LAMP_TEST_CYCLES - 1)
    && !restart_edge |=> s_r.st == panel_pkg::ST_CHECK ##1
    s_r.st == panel_pkg::ST_RUN)
    else $error("lamp test did not end at terminal count");

  AST_READY: assert property (
    s_r.st == panel_pkg::ST_RUN && diskette_seated[0]
    |=> lamps.ready[0] == !$past(s_r.standby))
    else $error("ready lamp wrong for seated drive");

  AST_BUSY: assert property (
    s_r.st != panel_pkg::ST_LAMP_TEST && disk_xfer_active[1] |=> lamps.busy[1])
    else $error("busy lamp dark during transfer");

  AST_ABORT: assert property (
    reset_cmd ##1 !drive_safe[0] |=> disk_abort == 1'b0 && s_r.abort_pend[0])
    else $error("abort not held until drive safe");

  AST_CARRIER: assert property (
    s_r.st == panel_pkg::ST_RUN |=> lamps.carrier == $past(carrier_detect))
    else $error("carrier lamp does not follow carrier detect");

  AST_PARITY_HOLD: assert property (
    s_r.parity && !reset_cmd |=> s_r.parity)
    else $error("parity indication dropped without reset command");

  AST_FULL: assert property (
    s_r.st == panel_pkg::ST_RUN && !s_r.cfg_bad && s_r.parity && !any_port
    |=> lamps.status)
    else $error("status lamp not full with latched parity");

  AST_CFG_BAD: assert property (
    s_r.cfg_bad && s_r.st == panel_pkg::ST_RUN |=> lamps.status && !op_enable)
    else $error("bad test byte not shown or not blocking");

  AST_SEL_HELD: assert property (
    s_r.st == panel_pkg::ST_RUN && !restart_edge |=> $stable(s_r.sel))
    else $error("selectors changed outside restart");

  AST_BINARY: assert property (
    binary_exit_switch |=> !binary_mode)
    else $error("binary mode on at exit position");

  AST_APB_ONE: assert property (
    apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held longer than one cycle");

  AST_READY_SPLIT: assert property (
    s_r.st != panel_pkg::ST_LAMP_TEST && !diskette_seated[1] |=> !lamps.ready[1])
    else $error("ready lamp lit by the other drive");

  AST_ABORT_PULSE: assert property (
    reset_cmd |=> disk_abort && s_r.abort_pend == 2'b11)
    else $error("reset command did not abort both drives");

  AST_DIM: assert property (
    s_r.st == panel_pkg::ST_RUN && !s_r.cfg_bad && any_port
    |=> lamps.status == $past(dim_phase))
    else $error("status lamp not dimmed during port traffic");

  AST_PARITY_CLEAR: assert property (
    s_r.parity && reset_cmd && !parity_error |=> !s_r.parity)
    else $error("reset command did not clear parity indication");

  AST_BAUD_TABLE: assert property (
    s_r.sel[0] == 4'h1 |=> baud_divisor[0] == panel_pkg::DIV_TAB[0])
    else $error("selector position 1 not mapped to table rate");

  AST_KEY_RATE: assert property (
    s_r.st == panel_pkg::ST_RUN && s_r.sel[2] == 4'h0
    |=> baud_divisor[2] == $past(s_r.keyrate[2]))
    else $error("selector position 0 not using keyboard rate");

  AST_RESTART_PULSE: assert property (
    restart_edge |=> system_restart && s_r.st == panel_pkg::ST_LAMP_TEST)
    else $error("restart press did not restart the system");

  COV_PARITY_CLEAR: cover property (s_r.parity ##1 reset_cmd ##1 !s_r.parity);
  COV_DIM: cover property (any_port && s_r.parity ##1 lamps.status ##1 !lamps.status);
  COV_REFRESH: cover property (s_r.cfg_bad ##1 cfg_refresh_done ##2 op_enable);
  COV_RESTART: cover property (restart_edge ##1 system_restart);
  COV_ABORT_SAFE: cover property (reset_cmd ##1 s_r.abort_pend == 2'b11
    ##[1:20] s_r.abort_pend == 2'b00);

endmodule : front_panel_indicator_ctrl

//--- shared/panel_pkg.sv
/*
  Shared constants, types and carriers for the front-panel indicator block.
  Assumes a 50 MHz system clock and an APB master with 32-bit data.
*/
package panel_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_HZ       = 50_000_000;
  localparam int unsigned LAMP_TEST_MS   = 500;
  localparam int unsigned LAMP_TEST_CYCLES_DEF = CLOCK_HZ / 1000 * LAMP_TEST_MS;
  // Dimming rate well above visible flicker
  localparam int unsigned DIM_HZ         = 1000;
  localparam int unsigned DIM_HALF_CYCLES_DEF  = CLOCK_HZ / (2 * DIM_HZ);

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_KEYRATE0 = 8'h08;
  localparam logic [7:0] OFS_KEYRATE1 = 8'h0c;
  localparam logic [7:0] OFS_KEYRATE2 = 8'h10;
  localparam logic [7:0] OFS_SELECT   = 8'h14;

  localparam int CTRL_RESET_BIT   = 0;
  localparam int CTRL_STANDBY_BIT = 1;
  localparam logic        STANDBY_RST = 1'b0;
  localparam logic [15:0] KEYRATE_RST = 16'h0145;

  // ----------------------------------------------------------------
  // Configuration test byte and baud table
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_TEST_EXPECTED = 8'h5a;
  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [15:0] DIV_TAB [9] = '{
    16'(CLOCK_HZ / (OVERSAMPLE * 110)),
    16'(CLOCK_HZ / (OVERSAMPLE * 150)),
    16'(CLOCK_HZ / (OVERSAMPLE * 300)),
    16'(CLOCK_HZ / (OVERSAMPLE * 600)),
    16'(CLOCK_HZ / (OVERSAMPLE * 1200)),
    16'(CLOCK_HZ / (OVERSAMPLE * 2400)),
    16'(CLOCK_HZ / (OVERSAMPLE * 4800)),
    16'(CLOCK_HZ / (OVERSAMPLE * 9600)),
    16'(CLOCK_HZ / (OVERSAMPLE * 19200))
  };

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_LAMP_TEST = 2'b00,
    ST_CHECK     = 2'b01,
    ST_RUN       = 2'b11
  } panel_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic [1:0] ready;
    logic [1:0] busy;
    logic       carrier;
    logic       status;
    logic       restart;
  } lamps_s;

endpackage : panel_pkg

//--- rtl/dim_gen.sv
/*
  Square-wave generator for half-brilliance lamp drive.
  Assumes one free-running clock and an active-high asynchronous reset.
*/
`timescale 1ns/1ps
module dim_gen #(
  parameter int unsigned HALF_CYCLES = panel_pkg::DIM_HALF_CYCLES_DEF
) (
  input  logic clock,
  input  logic rst,
  output logic phase
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        phase;
  } dim_state_s;

  dim_state_s s_r;
  dim_state_s s_nxt;

  // ----------------------------------------------------------------
  // Fifty percent duty toggle
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (s_r.cnt == 32'(HALF_CYCLES - 1)) begin
      s_nxt.cnt   = 32'h0;
      s_nxt.phase = ~s_r.phase;
    end else begin
      s_nxt.cnt = s_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign phase = s_r.phase;

endmodule : dim_gen

//--- tb/panel_operator.sv
/*
  Operator-side model: restart button, baud thumbwheels, binary switch.
  Assumes the bench sets the requested positions by non-blocking assignment.
*/
`timescale 1ns/1ps
module panel_operator (
  input  logic             clock,
  input  logic             rst,
  input  logic             press,
  input  logic [2:0][3:0]  sel_set,
  input  logic             bin_set,
  output logic             restart_switch,
  output logic [2:0][3:0]  baud_selector,
  output logic             binary_exit_switch
);
  logic [2:0] hold_r;

  // ----------------------------------------------------------------
  // Switches
  // ----------------------------------------------------------------
  // A human press lasts several clocks, not one edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold_r             <= 3'h0;
      baud_selector      <= '0;
      binary_exit_switch <= 1'b1;
    end else begin
      if (press) begin
        hold_r <= 3'h4;
      end else if (hold_r != 3'h0) begin
        hold_r <= hold_r - 3'h1;
      end
      baud_selector      <= sel_set;
      binary_exit_switch <= bin_set;
    end
  end

  assign restart_switch = (hold_r != 3'h0);
endmodule : panel_operator

//--- tb/tb.sv
/*
  Self-checking bench for the front-panel block, one task per scenario.
  Assumes short lamp-test and dimming counts set through parameters.
*/
`timescale 1ns/1ps
module tb;
  logic                  clock = 1'b0;
  logic                  rst   = 1'b1;
  panel_pkg::apb_req_s   req   = '0;
  panel_pkg::apb_rsp_s   rsp;
  panel_pkg::lamps_s     lamps;
  logic [1:0]            seated = '0, xfer = '0, safe = '0;
  logic [2:0]            port = '0;
  logic                  parity = 1'b0, carrier = 1'b0, refresh = 1'b0;
  logic                  press = 1'b0, bin_set = 1'b1;
  logic [2:0][3:0]       sel_set = '0, sel;
  logic [7:0]            cfgb = 8'h5a;
  logic                  rsw, bexit, bmode, op_en, srestart, abort;
  logic [2:0][15:0]      baud;
  logic [31:0]           q;
  logic                  e, hi, lo;
  int                    n_mismatch = 0, checked = 0, n_abort = 0, n_restart = 0, cyc_n = 0;

  always #10 clock = ~clock;

  front_panel_indicator_ctrl #(.LAMP_TEST_CYCLES(8), .DIM_HALF_CYCLES(2))
    front_panel_indicator_ctrl_i (.clock(clock), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .diskette_seated(seated), .disk_xfer_active(xfer), .drive_safe(safe),
    .port_xfer_active(port), .parity_error(parity), .carrier_detect(carrier),
    .restart_switch(rsw), .binary_exit_switch(bexit), .baud_selector(sel),
    .cfg_test_byte(cfgb), .cfg_refresh_done(refresh), .lamps(lamps), .baud_divisor(baud),
    .binary_mode(bmode), .op_enable(op_en), .system_restart(srestart), .disk_abort(abort));

  panel_operator panel_operator_i (.clock(clock), .rst(rst), .press(press),
    .sel_set(sel_set), .bin_set(bin_set), .restart_switch(rsw), .baud_selector(sel),
    .binary_exit_switch(bexit));

  // ----------------------------------------------------------------
  // Monitors and helpers
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    cyc_n++;
    if (abort === 1'b1) n_abort++;
    if (srestart === 1'b1) n_restart++;
    if (cyc_n == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Settled look just after an edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
    @(posedge clock);
    req.penable <= 1'b1;
    // No local limit: the cycle ceiling ends a hung transfer
    do begin
      @(posedge clock);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask : apb

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_lamp_test();
    cyc(2);
    chk(lamps, 32'h7f);
    cyc(20);
    chk(lamps, 32'h01);
    chk(op_en, 32'h1);
    apb(1'b0, panel_pkg::OFS_KEYRATE0, '0);
    chk(q, 32'h145);
    apb(1'b0, 8'h40, '0);
    chk(e, 32'h1);
    chk(q, 32'h0);
    $display("lamp test done");
  endtask : t_lamp_test

  task automatic t_drive();
    @(posedge clock) begin seated <= 2'b01; xfer <= 2'b10; carrier <= 1'b1; end
    cyc(3);
    chk(lamps.ready, 32'h1);
    chk(lamps.busy, 32'h2);
    chk(lamps.carrier, 32'h1);
    apb(1'b1, panel_pkg::OFS_CTRL, 32'h2);
    cyc(3);
    chk(lamps.ready, 32'h0);
    apb(1'b1, panel_pkg::OFS_CTRL, 32'h0);
    @(posedge clock) begin carrier <= 1'b0; xfer <= 2'b00; end
    cyc(3);
    chk({lamps.carrier, lamps.busy, lamps.ready}, 32'h1);
    $display("drive lamps done");
  endtask : t_drive

  task automatic t_status();
    @(posedge clock) parity <= 1'b1;
    @(posedge clock) parity <= 1'b0;
    cyc(3);
    chk(lamps.status, 32'h1);
    @(posedge clock) port <= 3'b010;
    cyc(2);
    hi = 1'b0;
    lo = 1'b0;
    repeat (8) begin
      cyc(1);
      if (lamps.status === 1'b1) hi = 1'b1;
      if (lamps.status === 1'b0) lo = 1'b1;
    end
    chk({hi, lo}, 32'h3);
    @(posedge clock) port <= 3'b000;
    cyc(3);
    chk(lamps.status, 32'h1);
    apb(1'b1, panel_pkg::OFS_CTRL, 32'h1);
    cyc(3);
    chk(lamps.status, 32'h0);
    chk(lamps.busy, 32'h3);
    chk(n_abort, 32'h1);
    apb(1'b0, panel_pkg::OFS_STATUS, '0);
    chk(q, 32'h39b9);
    chk(e, 32'h0);
    @(posedge clock) safe <= 2'b11;
    cyc(3);
    chk(lamps.busy, 32'h0);
    $display("status lamp done");
  endtask : t_status

  task automatic t_baud();
    apb(1'b1, panel_pkg::OFS_KEYRATE2, 32'h0123);
    @(posedge clock) begin sel_set <= {4'h0, 4'h9, 4'h1}; press <= 1'b1; end
    @(posedge clock) press <= 1'b0;
    cyc(25);
    chk(n_restart, 32'h1);
    chk(baud[0], panel_pkg::DIV_TAB[0]);
    chk(baud[1], panel_pkg::DIV_TAB[8]);
    chk(baud[2], 32'h0123);
    apb(1'b0, panel_pkg::OFS_SELECT, '0);
    chk(q, 32'h091);
    @(posedge clock) sel_set <= {4'h2, 4'h2, 4'h2};
    cyc(4);
    chk(baud[0], panel_pkg::DIV_TAB[0]);
    $display("baud select done");
  endtask : t_baud

  task automatic t_binary();
    cyc(2);
    chk(bmode, 32'h0);
    @(posedge clock) bin_set <= 1'b0;
    cyc(3);
    chk(bmode, 32'h1);
    $display("binary switch done");
  endtask : t_binary

  task automatic t_cfg();
    @(posedge clock) begin cfgb <= 8'h00; press <= 1'b1; end
    @(posedge clock) press <= 1'b0;
    cyc(25);
    chk(op_en, 32'h0);
    // Terminal port traffic; the status lamp stays full throughout
    @(posedge clock) port <= 3'b001;
    repeat (4) begin
      cyc(1);
      chk(lamps.status, 32'h1);
    end
    @(posedge clock) begin port <= 3'b000; cfgb <= 8'h5a; refresh <= 1'b1; end
    @(posedge clock) refresh <= 1'b0;
    cyc(3);
    chk({op_en, lamps.status}, 32'h2);
    $display("config check done");
  endtask : t_cfg

  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_lamp_test();
    t_drive();
    t_status();
    t_baud();
    t_binary();
    t_cfg();
    print_verdict();
  end
endmodule : tb
